/* verilog/sof_pkg.sv */
// Constants, register map and types for the serial output formatter.
// Assumes an 8-bit register port and a 20-bit left-aligned sample word.
`default_nettype none
package sof_pkg;
   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [7:0] SOF_ADDR_DRIVE   = 8'h1a;
   localparam logic [7:0] SOF_ADDR_RESMAP  = 8'h1b;
   localparam logic [7:0] SOF_ADDR_SKEW    = 8'h1e;
   localparam logic [7:0] SOF_ADDR_PAT_LO  = 8'h20;
   localparam logic [7:0] SOF_ADDR_PAT_MID = 8'h21;
   localparam logic [7:0] SOF_ADDR_PAT_HI  = 8'h22;
   localparam logic [7:0] SOF_ADDR_DIGPATH = 8'h24;
   localparam logic [7:0] SOF_ADDR_DECMODE = 8'h25;
   localparam logic [7:0] SOF_ADDR_STATUS  = 8'h27;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int SOF_HALF_DRIVE_BIT = 6;
   localparam int SOF_REMAP_EN_BIT   = 7;
   localparam int SOF_WIDE_BIT       = 6;
   localparam int SOF_RES_LSB        = 3;
   localparam int SOF_RES_MSB        = 5;
   localparam int SOF_DSKEW_LSB      = 2;
   localparam int SOF_DSKEW_MSB      = 3;
   localparam int SOF_CSKEW_LSB      = 0;
   localparam int SOF_CSKEW_MSB      = 1;
   localparam int SOF_SCR_BIT        = 6;
   localparam int SOF_PAT_HI_MSB     = 3;
   localparam int SOF_DIGPATH_BIT    = 2;
   localparam int SOF_DECEN_BIT      = 1;
   localparam int SOF_REAL_BIT       = 3;

   // ************************************************************
   // Reset values, codes and widths
   // ************************************************************
   localparam logic [7:0]  SOF_BYTE_ZERO  = 8'h00;
   localparam logic [19:0] SOF_PAT_RESET  = 20'hffc00;
   localparam logic [19:0] SOF_WORD_ZERO  = 20'h00000;
   localparam logic [2:0]  SOF_RES_18     = 3'h0;
   localparam logic [2:0]  SOF_RES_16     = 3'h1;
   localparam logic [2:0]  SOF_RES_14     = 3'h2;
   localparam logic [4:0]  SOF_W14        = 5'h0e;
   localparam logic [4:0]  SOF_W16        = 5'h10;
   localparam logic [4:0]  SOF_W18        = 5'h12;
   localparam logic [4:0]  SOF_W20        = 5'h14;
   localparam logic [4:0]  SOF_SLOT_ZERO  = 5'h00;
   localparam logic [4:0]  SOF_SLOT_ONE   = 5'h01;
   localparam logic [4:0]  SOF_PAT_MSB    = 5'h13;
   localparam logic [14:0] SOF_SCR_SEED   = 15'h7fff;
   localparam int          SOF_SCR_TAP_A  = 14;
   localparam int          SOF_SCR_TAP_B  = 13;
   localparam int          SOF_WORD_MSB   = 19;
   localparam int          SOF_CFG_W      = 27;
   // Bundle: width, pattern, auto pattern, scramble off
   localparam logic [26:0] SOF_CFG_RESET  = {SOF_W18, SOF_PAT_RESET, 1'b1, 1'b0};

   typedef enum logic [1:0] {
      SOF_XFER_IDLE = 2'b01,
      SOF_XFER_BUSY = 2'b10
   } sof_xfer_e;
endpackage
`default_nettype wire

/* verilog/sof_serial_output_formatter.sv */
// Serial output formatter: register file, width remap, frame clock and scrambler.
// Assumes core_clk at 40 MHz, link_clk the free-running serial bit clock, samples left-aligned.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Half drive bit selects reduced driver current
// - Remap enable changes width in bypass only
// - Wide enable forces 20-bit output words
// - Codes 000/001/010 give 18/16/14 bits in bypass remap and real decimation
// - Decimation modes use resolution select and real select, not remap enable
// - Data skew field shifts serial data timing
// - Clock skew field shifts bit clock timing
// - Twenty-bit frame pattern, reset 0xffc00
// - Bypass derives frame pattern from width
// - Scrambler needs digital path enable too
// - Digital path enable routes through features
// - Decimator enable turns decimation on, together with digital path enable
// - Real select picks real over complex
module sof_serial_output_formatter
   import sof_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output var  logic [7:0]  reg_rdata,
   input  wire logic [19:0] sample_data,
   input  wire logic        sample_valid,
   input  wire logic        link_clk,
   output var  logic        serial_data,
   output var  logic        frame_clock,
   output var  logic        output_half_drive,
   output var  logic [1:0]  data_lane_skew,
   output var  logic [1:0]  bit_clock_skew
);

   // ************************************************************
   // Core domain declarations
   // ************************************************************
   logic                 remap_en;
   logic                 wide_output_enable;
   logic [2:0]           output_resolution_select;
   logic [19:0]          frame_clock_pattern;
   logic                 scrambler_enable;
   logic                 digital_path_enable;
   logic                 decimator_enable;
   logic                 real_decim;
   logic                 decim_on;
   logic [4:0]           res_width;
   logic [4:0]           next_width;
   logic [4:0]           cfg_width;
   logic                 cfg_write;
   logic                 cfg_dirty;
   sof_xfer_e            cfg_state;
   logic                 cfg_tgl;
   logic [SOF_CFG_W-1:0] cfg_shadow;
   logic                 cfg_ack_m;
   logic                 cfg_ack_s;
   logic                 smp_busy;
   logic                 smp_tgl;
   logic [19:0]          smp_hold;
   logic                 smp_ack_m;
   logic                 smp_ack_s;

   // ************************************************************
   // Link domain declarations
   // ************************************************************
   logic                 l_rst_m;
   logic                 l_rst_n;
   logic                 l_cfg_m;
   logic                 l_cfg_s;
   logic                 l_cfg_d;
   logic                 l_cfg_ack;
   logic [SOF_CFG_W-1:0] l_cfg_new;
   logic                 l_cfg_upd;
   logic [4:0]           l_width;
   logic [19:0]          l_pat;
   logic                 l_auto;
   logic                 l_scr;
   logic                 l_smp_m;
   logic                 l_smp_s;
   logic                 l_smp_d;
   logic                 l_smp_ack;
   logic [19:0]          l_word;
   logic                 l_word_ok;
   logic [4:0]           l_slot;
   logic                 l_wrap;
   logic [19:0]          l_shift;
   logic [14:0]          l_lfsr;
   logic                 l_bit;
   logic                 l_scr_bit;

   // ************************************************************
   // Register file
   // ************************************************************
   // Writes store only the defined fields
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         output_half_drive        <= 1'b0;
         remap_en                 <= 1'b0;
         wide_output_enable       <= 1'b0;
         output_resolution_select <= SOF_RES_18;
         data_lane_skew           <= 2'b00;
         bit_clock_skew           <= 2'b00;
         frame_clock_pattern      <= SOF_PAT_RESET;
         scrambler_enable         <= 1'b0;
         digital_path_enable      <= 1'b0;
         decimator_enable         <= 1'b0;
         real_decim               <= 1'b0;
      end else if (reg_wr) begin
         unique case (reg_addr)
            SOF_ADDR_DRIVE: begin
               output_half_drive <= reg_wdata[SOF_HALF_DRIVE_BIT];
            end
            SOF_ADDR_RESMAP: begin
               remap_en                 <= reg_wdata[SOF_REMAP_EN_BIT];
               wide_output_enable       <= reg_wdata[SOF_WIDE_BIT];
               output_resolution_select <= reg_wdata[SOF_RES_MSB:SOF_RES_LSB];
            end
            SOF_ADDR_SKEW: begin
               data_lane_skew <= reg_wdata[SOF_DSKEW_MSB:SOF_DSKEW_LSB];
               bit_clock_skew <= reg_wdata[SOF_CSKEW_MSB:SOF_CSKEW_LSB];
            end
            SOF_ADDR_PAT_LO: begin
               frame_clock_pattern[7:0] <= reg_wdata;
            end
            SOF_ADDR_PAT_MID: begin
               frame_clock_pattern[15:8] <= reg_wdata;
            end
            SOF_ADDR_PAT_HI: begin
               frame_clock_pattern[19:16] <= reg_wdata[SOF_PAT_HI_MSB:0];
               scrambler_enable           <= reg_wdata[SOF_SCR_BIT];
            end
            SOF_ADDR_DIGPATH: begin
               digital_path_enable <= reg_wdata[SOF_DIGPATH_BIT];
               decimator_enable    <= reg_wdata[SOF_DECEN_BIT];
            end
            SOF_ADDR_DECMODE: begin
               real_decim <= reg_wdata[SOF_REAL_BIT];
            end
            default: begin
            end
         endcase
      end
   end

   // Read data valid only in the cycle after the strobe; reserved bits read zero
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= SOF_BYTE_ZERO;
      end else if (reg_rd) begin
         unique case (reg_addr)
            SOF_ADDR_DRIVE:   reg_rdata <= {1'b0, output_half_drive, 6'h00};
            SOF_ADDR_RESMAP:  reg_rdata <= {remap_en, wide_output_enable, output_resolution_select, 3'h0};
            SOF_ADDR_SKEW:    reg_rdata <= {4'h0, data_lane_skew, bit_clock_skew};
            SOF_ADDR_PAT_LO:  reg_rdata <= frame_clock_pattern[7:0];
            SOF_ADDR_PAT_MID: reg_rdata <= frame_clock_pattern[15:8];
            SOF_ADDR_PAT_HI:  reg_rdata <= {1'b0, scrambler_enable, 2'h0, frame_clock_pattern[19:16]};
            SOF_ADDR_DIGPATH: reg_rdata <= {5'h00, digital_path_enable, decimator_enable, 1'b0};
            SOF_ADDR_DECMODE: reg_rdata <= {4'h0, real_decim, 3'h0};
            SOF_ADDR_STATUS:  reg_rdata <= {1'b0, cfg_state == SOF_XFER_BUSY, decim_on, cfg_width};
            default:          reg_rdata <= SOF_BYTE_ZERO;
         endcase
      end else begin
         reg_rdata <= SOF_BYTE_ZERO;
      end
   end

   // ************************************************************
   // Output width selection
   // ************************************************************
   // Decimation runs only with the feature path and decimator both on
   assign decim_on = digital_path_enable && decimator_enable;

   // Resolution code to width; unsupported codes keep 18 bits
   assign res_width = (output_resolution_select == SOF_RES_16) ? SOF_W16 :
                      (output_resolution_select == SOF_RES_14) ? SOF_W14 : SOF_W18;

   // Width for the next frame
   always_comb begin
      next_width = SOF_W18;
      if (wide_output_enable) begin
         next_width = SOF_W20;
      end else if (decim_on) begin
         // Complex default is 16 bits, real default 18
         next_width = (!real_decim && output_resolution_select == SOF_RES_18) ? SOF_W16 : res_width;
      end else if (remap_en) begin
         next_width = res_width;
      end
   end

   // Registered width, shown in status
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_width <= SOF_W18;
      end else begin
         cfg_width <= next_width;
      end
   end

   // ************************************************************
   // Configuration crossing to the link domain
   // ************************************************************
   assign cfg_write = reg_wr && (reg_addr == SOF_ADDR_RESMAP || reg_addr == SOF_ADDR_PAT_LO ||
                      reg_addr == SOF_ADDR_PAT_MID || reg_addr == SOF_ADDR_PAT_HI ||
                      reg_addr == SOF_ADDR_DIGPATH || reg_addr == SOF_ADDR_DECMODE);

   // Dirty flag; a new write wins over the clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_dirty <= 1'b1;
      end else if (cfg_write) begin
         cfg_dirty <= 1'b1;
      end else if (cfg_state == SOF_XFER_IDLE) begin
         cfg_dirty <= 1'b0;
      end
   end

   // Toggle handshake; shadow stays stable until acknowledged
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_state  <= SOF_XFER_IDLE;
         cfg_tgl    <= 1'b0;
         cfg_shadow <= SOF_CFG_RESET;
      end else begin
         unique case (cfg_state)
            SOF_XFER_IDLE: begin
               if (cfg_dirty) begin
                  // Bypass uses automatic pattern; scrambling needs the feature path
                  cfg_shadow <= {next_width, frame_clock_pattern, !decim_on,
                                 scrambler_enable && digital_path_enable};
                  cfg_tgl    <= ~cfg_tgl;
                  cfg_state  <= SOF_XFER_BUSY;
               end
            end
            SOF_XFER_BUSY: begin
               if (cfg_ack_s == cfg_tgl) begin
                  cfg_state <= SOF_XFER_IDLE;
               end
            end
         endcase
      end
   end

   // Acknowledge synchronisers from the link domain
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ack_m <= 1'b0;
         cfg_ack_s <= 1'b0;
         smp_ack_m <= 1'b0;
         smp_ack_s <= 1'b0;
      end else begin
         cfg_ack_m <= l_cfg_ack;
         cfg_ack_s <= cfg_ack_m;
         smp_ack_m <= l_smp_ack;
         smp_ack_s <= smp_ack_m;
      end
   end

   // Sample hand-off; samples offered while busy are dropped
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         smp_busy <= 1'b0;
         smp_tgl  <= 1'b0;
         smp_hold <= SOF_WORD_ZERO;
      end else if (!smp_busy && sample_valid) begin
         smp_hold <= sample_data;
         smp_tgl  <= ~smp_tgl;
         smp_busy <= 1'b1;
      end else if (smp_busy && smp_ack_s == smp_tgl) begin
         smp_busy <= 1'b0;
      end
   end

   // ************************************************************
   // Link domain: reset release and synchronisers
   // ************************************************************
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         l_rst_m <= 1'b0;
         l_rst_n <= 1'b0;
      end else begin
         l_rst_m <= 1'b1;
         l_rst_n <= l_rst_m;
      end
   end

   // Toggle synchronisers and edge history
   always_ff @(posedge link_clk or negedge l_rst_n) begin
      if (!l_rst_n) begin
         l_cfg_m <= 1'b0;
         l_cfg_s <= 1'b0;
         l_cfg_d <= 1'b0;
         l_smp_m <= 1'b0;
         l_smp_s <= 1'b0;
         l_smp_d <= 1'b0;
      end else begin
         l_cfg_m <= cfg_tgl;
         l_cfg_s <= l_cfg_m;
         l_cfg_d <= l_cfg_s;
         l_smp_m <= smp_tgl;
         l_smp_s <= l_smp_m;
         l_smp_d <= l_smp_s;
      end
   end

   // Capture new configuration; applied at the next frame boundary
   always_ff @(posedge link_clk or negedge l_rst_n) begin
      if (!l_rst_n) begin
         l_cfg_new <= SOF_CFG_RESET;
         l_cfg_ack <= 1'b0;
         l_cfg_upd <= 1'b0;
         {l_width, l_pat, l_auto, l_scr} <= SOF_CFG_RESET;
      end else begin
         l_cfg_ack <= l_cfg_s;
         if (l_cfg_s != l_cfg_d) begin
            l_cfg_new <= cfg_shadow;
            l_cfg_upd <= 1'b1;
         end else if (l_wrap) begin
            l_cfg_upd <= 1'b0;
         end
         if (l_wrap && l_cfg_upd) begin
            {l_width, l_pat, l_auto, l_scr} <= l_cfg_new;
         end
      end
   end

   // Capture new sample word; a fresh word wins over the frame clear
   always_ff @(posedge link_clk or negedge l_rst_n) begin
      if (!l_rst_n) begin
         l_word    <= SOF_WORD_ZERO;
         l_word_ok <= 1'b0;
         l_smp_ack <= 1'b0;
      end else begin
         l_smp_ack <= l_smp_s;
         if (l_smp_s != l_smp_d) begin
            l_word    <= smp_hold;
            l_word_ok <= 1'b1;
         end else if (l_wrap) begin
            l_word_ok <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Link domain: serializer, frame clock and scrambler
   // ************************************************************
   assign l_wrap    = (l_slot == l_width - SOF_SLOT_ONE);
   assign l_bit     = l_shift[SOF_WORD_MSB];
   assign l_scr_bit = l_bit ^ l_lfsr[SOF_SCR_TAP_A] ^ l_lfsr[SOF_SCR_TAP_B];

   // Slot counter and shift register, MSB first
   always_ff @(posedge link_clk or negedge l_rst_n) begin
      if (!l_rst_n) begin
         l_slot  <= SOF_SLOT_ZERO;
         l_shift <= SOF_WORD_ZERO;
      end else if (l_wrap) begin
         l_slot  <= SOF_SLOT_ZERO;
         l_shift <= l_word_ok ? l_word : SOF_WORD_ZERO;
      end else begin
         l_slot  <= l_slot + SOF_SLOT_ONE;
         l_shift <= {l_shift[18:0], 1'b0};
      end
   end

   // Data lane with optional self-synchronising scrambler
   always_ff @(posedge link_clk or negedge l_rst_n) begin
      if (!l_rst_n) begin
         serial_data <= 1'b0;
         l_lfsr      <= SOF_SCR_SEED;
      end else begin
         serial_data <= l_scr ? l_scr_bit : l_bit;
         if (l_scr) begin
            l_lfsr <= {l_lfsr[13:0], l_scr_bit};
         end
      end
   end

   // Frame clock: pattern bit per slot, or first half high in bypass
   always_ff @(posedge link_clk or negedge l_rst_n) begin
      if (!l_rst_n) begin
         frame_clock <= 1'b0;
      end else if (l_auto) begin
         frame_clock <= (l_slot < (l_width >> 1));
      end else begin
         frame_clock <= l_pat[SOF_PAT_MSB - l_slot];
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   sequence s_drive_write;
      reg_wr && reg_addr == SOF_ADDR_DRIVE;
   endsequence
   sequence s_skew_write;
      reg_wr && reg_addr == SOF_ADDR_SKEW;
   endsequence

   property p_half_drive;
      @(posedge core_clk) disable iff (!rst_n)
      s_drive_write |=> output_half_drive == $past(reg_wdata[SOF_HALF_DRIVE_BIT]);
   endproperty
   a_half_drive: assert property (p_half_drive) else $error("half drive not taken");

   property p_remap_bypass;
      @(posedge core_clk) disable iff (!rst_n)
      (!decim_on && !wide_output_enable && remap_en && output_resolution_select == SOF_RES_16)
      |=> cfg_width == SOF_W16;
   endproperty
   a_remap_bypass: assert property (p_remap_bypass) else $error("bypass remap width wrong");

   property p_no_remap_bypass;
      @(posedge core_clk) disable iff (!rst_n)
      (!decim_on && !wide_output_enable && !remap_en) |=> cfg_width == SOF_W18;
   endproperty
   a_no_remap_bypass: assert property (p_no_remap_bypass) else $error("bypass width not native");

   property p_wide;
      @(posedge core_clk) disable iff (!rst_n)
      wide_output_enable |=> cfg_width == SOF_W20;
   endproperty
   a_wide: assert property (p_wide) else $error("wide output not 20 bits");

   property p_real_14;
      @(posedge core_clk) disable iff (!rst_n)
      (decim_on && real_decim && !wide_output_enable && output_resolution_select == SOF_RES_14)
      |=> cfg_width == SOF_W14;
   endproperty
   a_real_14: assert property (p_real_14) else $error("real decimation 14-bit wrong");

   property p_complex_default;
      @(posedge core_clk) disable iff (!rst_n)
      (decim_on && !real_decim && !wide_output_enable && output_resolution_select == SOF_RES_18)
      |=> cfg_width == SOF_W16;
   endproperty
   a_complex_default: assert property (p_complex_default) else $error("complex default not 16");

   property p_skew;
      @(posedge core_clk) disable iff (!rst_n)
      s_skew_write |=> data_lane_skew == $past(reg_wdata[SOF_DSKEW_MSB:SOF_DSKEW_LSB])
                    && bit_clock_skew == $past(reg_wdata[SOF_CSKEW_MSB:SOF_CSKEW_LSB]);
   endproperty
   a_skew: assert property (p_skew) else $error("skew fields not taken");

   property p_pat_read;
      @(posedge core_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == SOF_ADDR_PAT_MID) |=> reg_rdata == $past(frame_clock_pattern[15:8]);
   endproperty
   a_pat_read: assert property (p_pat_read) else $error("pattern readback wrong");

   property p_frame_msb;
      @(posedge link_clk) disable iff (!l_rst_n)
      (l_slot == SOF_SLOT_ZERO && !l_auto) |=> frame_clock == $past(l_pat[SOF_WORD_MSB]);
   endproperty
   a_frame_msb: assert property (p_frame_msb) else $error("frame clock not pattern msb");

   property p_auto_frame;
      @(posedge link_clk) disable iff (!l_rst_n)
      (l_slot == SOF_SLOT_ZERO && l_auto) |=> frame_clock ##1 frame_clock;
   endproperty
   a_auto_frame: assert property (p_auto_frame) else $error("auto frame clock low at start");

   property p_scr_off;
      @(posedge link_clk) disable iff (!l_rst_n)
      !l_scr |=> serial_data == $past(l_shift[SOF_WORD_MSB]);
   endproperty
   a_scr_off: assert property (p_scr_off) else $error("data altered with scrambler off");

endmodule
`default_nettype wire

/* sim/sof_link_rx.sv */
// Far-side receiver model: measures the frame clock high run and deserializes the lane.
// Assumes link_clk from the bench and the formatter link outputs.
`timescale 1ns/1ps
`default_nettype none
// ********
// Receiver
// ********
module sof_link_rx (
   input  wire logic        link_clk,
   input  wire logic        rst_n,
   input  wire logic        frame_clock,
   input  wire logic        serial_data,
   input  wire logic        descr,
   output var  logic [4:0]  high_run,
   output var  logic [19:0] rx_word
);
   logic [4:0]  cnt;
   logic        fc_d;
   logic        dbit;
   logic [14:0] rx_lfsr;
   logic [19:0] rx_shift;
   // Self-synchronising descrambler on received lane bits
   assign dbit = serial_data ^ (descr & (rx_lfsr[14] ^ rx_lfsr[13]));
   // Count high slots, latch on fall
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 5'h00;
         high_run <= 5'h00;
      end else if (frame_clock) begin
         cnt <= cnt + 5'h01;
      end else begin
         if (cnt != 5'h00) high_run <= cnt;
         cnt <= 5'h00;
      end
   end
   // Shift lane bits in; frame clock rise closes the previous frame
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         fc_d     <= 1'b0;
         rx_lfsr  <= 15'h0000;
         rx_shift <= 20'h00000;
         rx_word  <= 20'h00000;
      end else begin
         fc_d     <= frame_clock;
         rx_lfsr  <= {rx_lfsr[13:0], serial_data};
         rx_shift <= {rx_shift[18:0], dbit};
         if (frame_clock && !fc_d) rx_word <= rx_shift;
      end
   end
endmodule
`default_nettype wire

/* sim/serial_output_formatter_tb.sv */
// Testbench for the serial output formatter: registers, widths, frame clock.
// Assumes the design package and the link receiver model.
`timescale 1ns/1ps
`default_nettype none
// ********
// Bench
// ********
module serial_output_formatter_tb import sof_pkg::*;;
   logic        core_clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0;
   logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v, m;
   logic        reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0, sample_valid = 1'b0;
   logic [19:0] sample_data = 20'h00000;
   logic        serial_data, frame_clock, output_half_drive;
   logic [1:0]  data_lane_skew, bit_clock_skew;
   logic [4:0]  high_run;
   logic [19:0] smp_fix = 20'h00000, rx_word;
   logic        descr = 1'b0;
   logic [4:0]  wtab [4] = '{SOF_W18, SOF_W16, SOF_W14, SOF_W18};
   logic [7:0]  exp_q [$], mask_q [$];
   int          bad_count = 0, samples_checked = 0;

   sof_serial_output_formatter i_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sample_data(sample_data), .sample_valid(sample_valid), .link_clk(link_clk),
      .serial_data(serial_data), .frame_clock(frame_clock), .output_half_drive(output_half_drive),
      .data_lane_skew(data_lane_skew), .bit_clock_skew(bit_clock_skew));
   sof_link_rx i_rx (.link_clk(link_clk), .rst_n(rst_n), .frame_clock(frame_clock), .serial_data(serial_data),
      .descr(descr), .high_run(high_run), .rx_word(rx_word));

   // Clocks, link offset in phase
   always #12.5 core_clk = ~core_clk;
   initial begin
      #7;
      forever #62.5 link_clk = ~link_clk;
   end
   // Sample stream: one random word, repeated
   always @(posedge core_clk) begin
      sample_data <= smp_fix;
      sample_valid <= rst_n;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic chk_word(input logic [19:0] e);
      check(rx_word[7:0], e[7:0]);
      check(rx_word[15:8], e[15:8]);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] mk);
      exp_q.push_back(e & mk);
      mask_q.push_back(mk);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask
   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Read data watcher, oldest note first
   always @(posedge core_clk) begin
      rd_d <= reg_rd;
      if (rd_d) begin
         m = mask_q.pop_front();
         check(reg_rdata & m, exp_q.pop_front());
      end
   end
   // Watchdog
   initial begin
      #2_000_000;
      bad_count++;
      report_and_stop;
   end

   initial begin
      void'($urandom(98));
      smp_fix = 20'($urandom) | 20'h80000;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(SOF_ADDR_DRIVE, 8'h00, 8'hff);
      rd(SOF_ADDR_PAT_MID, 8'hfc, 8'hff);
      rd(SOF_ADDR_PAT_HI, 8'h0f, 8'h0f);
      rd(8'h30, 8'h00, 8'hff);
      repeat (300) @(posedge core_clk);
      check({3'h0, high_run}, 8'h09);
      chk_word({2'h0, smp_fix[19:2]});
      check({6'h0, rx_word[17:16]}, {6'h0, smp_fix[19:18]});
      wr(SOF_ADDR_DRIVE, 8'h40);
      @(negedge core_clk);
      check({7'h0, output_half_drive}, 8'h01);
      repeat (4) begin
         v = 8'($urandom) & 8'h0f;
         wr(SOF_ADDR_SKEW, v);
         @(negedge core_clk);
         check({6'h0, data_lane_skew}, {6'h0, v[3:2]});
         check({6'h0, bit_clock_skew}, {6'h0, v[1:0]});
         rd(SOF_ADDR_SKEW, v, 8'hff);
      end
      $display("test drive and skew done");
      for (int c = 0; c < 4; c++) begin
         wr(SOF_ADDR_RESMAP, 8'h80 | 8'(c << 3));
         rd(SOF_ADDR_STATUS, {3'h0, wtab[c]}, 8'h3f);
      end
      wr(SOF_ADDR_RESMAP, 8'h90);
      repeat (600) @(posedge core_clk);
      check({3'h0, high_run}, 8'h07);
      wr(SOF_ADDR_RESMAP, 8'h40);
      rd(SOF_ADDR_STATUS, 8'h14, 8'h3f);
      wr(SOF_ADDR_RESMAP, 8'h10);
      rd(SOF_ADDR_STATUS, 8'h12, 8'h3f);
      $display("test bypass widths done");
      wr(SOF_ADDR_DIGPATH, 8'h06);
      wr(SOF_ADDR_DECMODE, 8'h08);
      wr(SOF_ADDR_RESMAP, 8'h00);
      rd(SOF_ADDR_STATUS, 8'h32, 8'h3f);
      wr(SOF_ADDR_RESMAP, 8'h10);
      rd(SOF_ADDR_STATUS, 8'h2e, 8'h3f);
      wr(SOF_ADDR_RESMAP, 8'h00);
      wr(SOF_ADDR_DECMODE, 8'h00);
      rd(SOF_ADDR_STATUS, 8'h30, 8'h3f);
      wr(SOF_ADDR_PAT_LO, 8'h00);
      wr(SOF_ADDR_PAT_MID, 8'hf0);
      wr(SOF_ADDR_PAT_HI, 8'h4f);
      wr(SOF_ADDR_DECMODE, 8'h08);
      wr(SOF_ADDR_RESMAP, 8'h08);
      descr <= 1'b1;
      rd(SOF_ADDR_PAT_HI, 8'h4f, 8'hff);
      rd(SOF_ADDR_STATUS, 8'h30, 8'h3f);
      repeat (600) @(posedge core_clk);
      check({3'h0, high_run}, 8'h08);
      chk_word({4'h0, smp_fix[19:4]});
      $display("test decimation done");
      wr(SOF_ADDR_DECMODE, 8'h00);
      wr(SOF_ADDR_PAT_LO, 8'hff);
      wr(SOF_ADDR_PAT_MID, 8'hff);
      wr(SOF_ADDR_PAT_HI, 8'h0f);
      rd(SOF_ADDR_PAT_MID, 8'hff, 8'hff);
      repeat (300) @(posedge core_clk);
      check({7'h0, frame_clock}, 8'h01);
      $display("test complex pattern done");
      report_and_stop;
   end
endmodule
`default_nettype wire
